// ==== rtl/phy_test_status_led_regs.svh ====
`ifndef PHY_TEST_STATUS_LED_REGS_SVH
`define PHY_TEST_STATUS_LED_REGS_SVH
`define RECEIVE_ERROR_COUNTER_IDX     5'h15
`define SELF_TEST_IDX      5'h16
`define GEN_STATUS_TWO_IDX 5'h17
`define LED_SOURCE_IDX     5'h18
`define SELF_TEST_WMASK    16'hF3FF
`define STATUS_TWO_RESET   16'h0040
`define GPIO_LAMP_RESET    4'h6
`define PATGEN_ON          4'hF
`define PATGEN_OFF         4'h0
`define ST_PATGEN_HI       15
`define ST_PATGEN_LO       12
`define ST_REV_FWD_BIT     7
`define ST_MII_TX_BIT      6
`define ST_LOOP_HI         5
`define ST_LOOP_LO         2
`define BLINK_TIME_MS      50
`define CLK_KHZ            25000
`define BLINK_CYCLES       (`BLINK_TIME_MS * `CLK_KHZ)
`endif

// ==== rtl/phy_test_status_led_pkg.sv ====
package phy_test_status_led_pkg;
  typedef enum logic [3:0] {
    LOOP_NONE     = 4'h0,
    LOOP_DIGITAL  = 4'h1,
    LOOP_ANALOG   = 4'h2,
    LOOP_EXTERNAL = 4'h4,
    LOOP_REVERSE  = 4'h8
  } loop_select_t;
  typedef enum logic [1:0] {
    PCS_OFF      = 2'h0,
    PCS_PRE_SCR  = 2'h1,
    PCS_POST_SCR = 2'h2,
    PCS_FULL     = 2'h3
  } pcs_loop_t;
  typedef struct packed {
    logic link_good;
    logic rx_act;
    logic tx_act;
    logic collision;
    logic link_1000;
    logic link_100;
    logic link_10;
    logic full_duplex;
    logic copper;
    logic rx_err;
    logic tx_err;
  } lamp_events_t;
  typedef struct packed {
    logic pd_found;
    logic pd_no_signal;
    logic pd_watchdog;
    logic pd_absent;
    logic checker_synced;
    logic generator_active;
    logic legacy_master;
    logic legacy_slave;
    logic core_power_normal;
  } core_status_t;
  typedef struct packed {
    logic       pattern_generator_enable;
    logic       reverse_loop_forward_to_mac;
    logic       mii_loop_transmit_to_line;
    logic       loop_digital;
    logic       loop_analog;
    logic       loop_external;
    logic       loop_reverse;
    logic       pcs_loop_pre_scrambler;
    logic       pcs_loop_pre_encoder;
    logic       pcs_loop_full;
    logic       pcs_loop_gigabit;
  } test_controls_t;
endpackage : phy_test_status_led_pkg

// ==== rtl/phy_test_status_led_top.sv ====
`timescale 1ns/1ns
`include "phy_test_status_led_regs.svh"
module phy_test_status_led_top #(
  parameter int unsigned BLINK_CYCLES = `BLINK_CYCLES
) (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic                                  clk_en,
  input  wire logic [11:0]                           lamp_strap,
  input  wire logic                                  rx_error_event,
  input  wire logic                                  gigabit_mode,
  input  wire logic                                  checker_sync_lost,
  input  wire phy_test_status_led_pkg::core_status_t core_status,
  input  wire phy_test_status_led_pkg::lamp_events_t lamp_events,
  input  wire logic [6:0]                            s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  input  wire logic [6:0]                            s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  output phy_test_status_led_pkg::test_controls_t    test_controls,
  output logic [3:0]                                 lamp_out
);

  logic [15:0] receive_error_counter_reg;
  logic [15:0] self_test_reg;
  logic [3:0]  pd_flags_reg;
  logic        sync_lost_reg;
  logic [15:0] lamp_source_reg;
  logic        strap_loaded_reg;
  logic [6:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;

  // external event inputs pass two flops
  logic [1:0]  rx_err_sync_reg;
  logic [1:0]  lost_sync_reg;
  logic [1:0]  gig_sync_reg;
  logic        rx_err_d_reg;
  logic        lost_d_reg;
  phy_test_status_led_pkg::core_status_t cs_meta_reg;
  phy_test_status_led_pkg::core_status_t cs_reg;
  phy_test_status_led_pkg::lamp_events_t ev_meta_reg;
  phy_test_status_led_pkg::lamp_events_t ev_reg;

  logic        wr_fire;
  logic        rd_fire;
  logic [4:0]  wr_idx;
  logic [4:0]  rd_idx;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] rx_err_kept;
  logic [3:0]  lamp_lit;
  logic        rx_err_pulse;
  logic        lost_pulse;
  logic        status_read;
  logic [15:0] status_word;
  logic [15:0] rd_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_err_sync_reg <= 2'h0;
      lost_sync_reg   <= 2'h0;
      gig_sync_reg    <= 2'h0;
      rx_err_d_reg    <= 1'b0;
      lost_d_reg      <= 1'b0;
      cs_meta_reg     <= '0;
      cs_reg          <= '0;
      ev_meta_reg     <= '0;
      ev_reg          <= '0;
    end else if (clk_en) begin
      rx_err_sync_reg <= {rx_err_sync_reg[0], rx_error_event};
      lost_sync_reg   <= {lost_sync_reg[0], checker_sync_lost};
      gig_sync_reg    <= {gig_sync_reg[0], gigabit_mode};
      rx_err_d_reg    <= rx_err_sync_reg[1];
      lost_d_reg      <= lost_sync_reg[1];
      cs_meta_reg     <= core_status;
      cs_reg          <= cs_meta_reg;
      ev_meta_reg     <= lamp_events;
      ev_reg          <= ev_meta_reg;
    end
  end

  assign rx_err_pulse = rx_err_sync_reg[1] & ~rx_err_d_reg;
  assign lost_pulse   = lost_sync_reg[1] & ~lost_d_reg;

  // write channels are captured independently, then committed together
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_idx  = aw_addr_reg[6:2];
  assign wr_hit  = (aw_addr_reg[1:0] == 2'h0) &&
                   (wr_idx >= `RECEIVE_ERROR_COUNTER_IDX) && (wr_idx <= `LED_SOURCE_IDX);
  assign wmask   = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wval    = w_data_reg[15:0];
  assign rx_err_kept = receive_error_counter_reg & ~(wval & wmask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 7'h00;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_wready <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // receive error count: saturates at FFFF; an event in a write-one-clear cycle is added after the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_error_counter_reg <= 16'h0000;
    end else if (clk_en) begin
      if (wr_fire && wr_hit && wr_idx == `RECEIVE_ERROR_COUNTER_IDX) begin
        receive_error_counter_reg <= rx_err_kept +
                          {15'h0000, rx_err_pulse && rx_err_kept != 16'hFFFF};
      end else if (rx_err_pulse && receive_error_counter_reg != 16'hFFFF) begin
        receive_error_counter_reg <= receive_error_counter_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      self_test_reg <= 16'h0000;
    end else if (clk_en && wr_fire && wr_hit && wr_idx == `SELF_TEST_IDX) begin
      self_test_reg <= (self_test_reg & ~(wmask & `SELF_TEST_WMASK)) |
                       (wval & wmask & `SELF_TEST_WMASK);
    end
  end

  // lamp sources: gpio fixed reset, others loaded from straps after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp_source_reg  <= {`GPIO_LAMP_RESET, 12'h000};
      strap_loaded_reg <= 1'b0;
    end else if (clk_en) begin
      if (!strap_loaded_reg) begin
        lamp_source_reg[11:0] <= lamp_strap;
        strap_loaded_reg      <= 1'b1;
      end else if (wr_fire && wr_hit && wr_idx == `LED_SOURCE_IDX) begin
        lamp_source_reg <= (lamp_source_reg & ~wmask) | (wval & wmask);
      end
    end
  end

  // read channel
  assign rd_fire     = s_axi_arvalid & s_axi_arready;
  assign rd_idx      = s_axi_araddr[6:2];
  assign rd_hit      = (s_axi_araddr[1:0] == 2'h0) &&
                       (rd_idx >= `RECEIVE_ERROR_COUNTER_IDX) && (rd_idx <= `LED_SOURCE_IDX);
  assign status_read = rd_fire && rd_hit && rd_idx == `GEN_STATUS_TWO_IDX;

  assign status_word = {pd_flags_reg,
                        cs_reg.checker_synced,
                        sync_lost_reg,
                        cs_reg.generator_active,
                        cs_reg.legacy_master,
                        cs_reg.legacy_slave,
                        cs_reg.core_power_normal | ~strap_loaded_reg,
                        6'h00};

  always_comb begin
    unique case (rd_idx)
      `RECEIVE_ERROR_COUNTER_IDX:     rd_word = receive_error_counter_reg;
      `SELF_TEST_IDX:      rd_word = self_test_reg;
      `GEN_STATUS_TWO_IDX: rd_word = status_word;
      `LED_SOURCE_IDX:     rd_word = lamp_source_reg;
      default:             rd_word = 16'h0000;
    endcase
  end

  // read-clear flags; a new event in the read cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_flags_reg  <= 4'h0;
      sync_lost_reg <= 1'b0;
    end else if (clk_en) begin
      pd_flags_reg  <= (status_read ? 4'h0 : pd_flags_reg) |
                       {cs_reg.pd_found, cs_reg.pd_no_signal,
                        cs_reg.pd_watchdog, cs_reg.pd_absent};
      sync_lost_reg <= (status_read ? 1'b0 : sync_lost_reg) | lost_pulse;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_hit ? rd_word : 16'h0000};
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // decoded test controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_controls <= '0;
    end else if (clk_en) begin
      test_controls.pattern_generator_enable <=
        self_test_reg[`ST_PATGEN_HI:`ST_PATGEN_LO] == `PATGEN_ON;
      test_controls.reverse_loop_forward_to_mac <=
        self_test_reg[`ST_REV_FWD_BIT] &&
        self_test_reg[`ST_LOOP_HI:`ST_LOOP_LO] == phy_test_status_led_pkg::LOOP_REVERSE;
      test_controls.mii_loop_transmit_to_line <= self_test_reg[`ST_MII_TX_BIT];
      test_controls.loop_digital  <= self_test_reg[5:2] == phy_test_status_led_pkg::LOOP_DIGITAL;
      test_controls.loop_analog   <= self_test_reg[5:2] == phy_test_status_led_pkg::LOOP_ANALOG;
      test_controls.loop_external <=
        self_test_reg[5:2] == phy_test_status_led_pkg::LOOP_EXTERNAL;
      test_controls.loop_reverse  <= self_test_reg[5:2] == phy_test_status_led_pkg::LOOP_REVERSE;
      test_controls.pcs_loop_pre_scrambler <=
        !gig_sync_reg[1] && self_test_reg[1:0] == phy_test_status_led_pkg::PCS_PRE_SCR;
      test_controls.pcs_loop_pre_encoder <=
        !gig_sync_reg[1] && self_test_reg[1:0] == phy_test_status_led_pkg::PCS_POST_SCR;
      test_controls.pcs_loop_full <=
        !gig_sync_reg[1] && self_test_reg[1:0] == phy_test_status_led_pkg::PCS_FULL;
      test_controls.pcs_loop_gigabit <= gig_sync_reg[1] && self_test_reg[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else if (clk_en) begin
      if (blink_cnt_reg >= BLINK_CYCLES - 1) begin
        blink_cnt_reg <= 32'h0000_0000;
        blink_reg     <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // per-lamp source multiplexer
  for (genvar i = 0; i < 4; i++) begin : g_lamp
    logic [3:0] sel;
    logic       lit;
    assign sel = lamp_source_reg[4*i +: 4];
    always_comb begin
      unique case (sel)
        4'h0: lit = ev_reg.link_good;
        4'h1: lit = ev_reg.rx_act | ev_reg.tx_act;
        4'h2: lit = ev_reg.tx_act;
        4'h3: lit = ev_reg.rx_act;
        4'h4: lit = ev_reg.collision;
        4'h5: lit = ev_reg.link_1000;
        4'h6: lit = ev_reg.link_100;
        4'h7: lit = ev_reg.link_10;
        4'h8: lit = ev_reg.link_10 | ev_reg.link_100;
        4'h9: lit = ev_reg.link_100 | ev_reg.link_1000;
        4'hA: lit = ev_reg.full_duplex;
        4'hB: lit = ev_reg.link_good & ev_reg.copper &
                    ~((ev_reg.rx_act | ev_reg.tx_act) & blink_reg);
        4'hD: lit = ev_reg.rx_err | ev_reg.tx_err;
        4'hE: lit = ev_reg.rx_err;
        default: lit = 1'b0;
      endcase
    end
    assign lamp_lit[i] = lit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp_out <= 4'h0;
    end else if (clk_en) begin
      lamp_out <= lamp_lit;
    end
  end

endmodule : phy_test_status_led_top

// ==== verif/phy_test_status_led_checker.sv ====
`timescale 1ns/1ns
module phy_test_status_led_checker (
  input wire logic                                    aclk,
  input wire logic                                    aresetn,
  input wire logic                                    clk_en,
  input wire logic                                    s_axi_awvalid,
  input wire logic                                    s_axi_awready,
  input wire logic                                    s_axi_wvalid,
  input wire logic                                    s_axi_wready,
  input wire logic                                    s_axi_bvalid,
  input wire logic                                    s_axi_bready,
  input wire logic [6:0]                              s_axi_araddr,
  input wire logic                                    s_axi_arvalid,
  input wire logic                                    s_axi_arready,
  input wire logic [31:0]                             s_axi_rdata,
  input wire logic [1:0]                              s_axi_rresp,
  input wire logic                                    s_axi_rvalid,
  input wire logic                                    s_axi_rready,
  input wire phy_test_status_led_pkg::test_controls_t test_controls
);
  logic [6:0]  ar_q;
  logic [10:0] tc;
  assign tc = test_controls;
  // address of the read now being answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= 7'h00;
    end else if (clk_en && s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_loop_onehot: assert property ($onehot0(tc[7:4]))
    else $error("more than one loop point selected");
  chk_fwd_needs_rev: assert property (tc[9] |-> tc[4])
    else $error("forward to mac outside reverse loop");
  chk_pcs_exclusive: assert property ($onehot0(tc[3:0]))
    else $error("more than one pcs loop point selected");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  chk_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && clk_en |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_unmapped_err: assert property (s_axi_rvalid && !(ar_q inside {7'h54, 7'h58, 7'h5C,
    7'h60}) |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  cov_status_read: cover property (s_axi_rvalid && ar_q == 7'h5C);
  cov_rev_forward: cover property (tc[9]);
  cov_refused_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : phy_test_status_led_checker

bind phy_test_status_led_top phy_test_status_led_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .test_controls(test_controls)
);

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        rx_error_event = 1'b0;
  logic        gigabit_mode = 1'b0;
  logic        checker_sync_lost = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [6:0]  s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_bresp;
  logic [3:0]  lamp_out;
  phy_test_status_led_pkg::core_status_t   core_status = 9'h001;
  phy_test_status_led_pkg::lamp_events_t   lamp_events = 11'h000;
  phy_test_status_led_pkg::test_controls_t test_controls;
  int          fail_count = 0;
  int          n_tests = 0;

  phy_test_status_led_top #(.BLINK_CYCLES(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .lamp_strap(12'h123),
    .rx_error_event(rx_error_event), .gigabit_mode(gigabit_mode),
    .checker_sync_lost(checker_sync_lost), .core_status(core_status), .lamp_events(lamp_events),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .test_controls(test_controls),
    .lamp_out(lamp_out)
  );

  always #20 aclk = ~aclk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // readies are registered, so the level at the falling edge is the one taken
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready === 1'b1;
      tw = pw && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    last_bresp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("register value", {16'h0000, e}, d);
    chk("read response", 32'h0, {30'h0, r});
  endtask : rc

  function automatic logic lamp_exp(input logic [3:0] c, input logic [10:0] e);
    case (c)
      4'h0: return e[10];
      4'h1: return e[9] | e[8];
      4'h2: return e[8];
      4'h3: return e[9];
      4'h4: return e[7];
      4'h5: return e[6];
      4'h6: return e[5];
      4'h7: return e[4];
      4'h8: return e[5] | e[4];
      4'h9: return e[6] | e[5];
      4'hA: return e[3];
      4'hB: return e[10] & e[2];
      4'hD: return e[1] | e[0];
      4'hE: return e[1];
      default: return 1'b0;
    endcase
  endfunction : lamp_exp

  task automatic t_reset_vals;
    rc(7'h54, 16'h0000);
    rc(7'h58, 16'h0000);
    rc(7'h5C, 16'h0040);
    rc(7'h60, 16'h6123);
  endtask : t_reset_vals

  task automatic t_bus_errors;
    logic [31:0] d;
    logic [1:0]  r;
    rd(7'h64, d, r);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    rd(7'h55, d, r);
    chk("unaligned rresp", 32'h2, {30'h0, r});
    wr(7'h70, 16'hFFFF);
    chk("unmapped bresp", 32'h2, {30'h0, last_bresp});
    wr(7'h5C, 16'hFFFF);
    rc(7'h5C, 16'h0040);
  endtask : t_bus_errors

  // entries: gigabit nibble, written word, expected controls
  task automatic t_self_test;
    logic [31:0] t [13] = '{32'h0F000400, 32'h05000000, 32'h00004080, 32'h00044180,
      32'h00008040, 32'h00010020, 32'h00020010, 32'h000A0210, 32'h00001008,
      32'h00002004, 32'h00003002, 32'h10001001, 32'h10003001};
    for (int i = 0; i < 13; i++) begin
      gigabit_mode <= t[i][28];
      repeat (5) @(posedge aclk);
      wr(7'h58, t[i][27:12]);
      repeat (2) @(posedge aclk);
      chk("test_controls", {20'h0, t[i][11:0]}, {21'h0, test_controls});
    end
    wr(7'h58, 16'hFFA0);
    rc(7'h58, 16'hF3A0);
    wr(7'h58, 16'h0000);
  endtask : t_self_test

  task automatic t_err_count;
    repeat (3) begin
      rx_error_event <= 1'b1;
      repeat (3) @(posedge aclk);
      rx_error_event <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    rc(7'h54, 16'h0003);
    wr(7'h54, 16'h0001);
    rc(7'h54, 16'h0002);
    wr(7'h54, 16'h0002);
    rc(7'h54, 16'h0000);
  endtask : t_err_count

  // an event seen only while the clock enable is low must leave no trace
  task automatic t_freeze;
    clk_en <= 1'b0;
    rx_error_event <= 1'b1;
    repeat (3) @(posedge aclk);
    rx_error_event <= 1'b0;
    repeat (3) @(posedge aclk);
    clk_en <= 1'b1;
    repeat (3) @(posedge aclk);
    rc(7'h54, 16'h0000);
  endtask : t_freeze

  task automatic t_status;
    core_status <= 9'h11D;
    checker_sync_lost <= 1'b1;
    repeat (5) @(posedge aclk);
    core_status.pd_found <= 1'b0;
    repeat (5) @(posedge aclk);
    rc(7'h5C, 16'h8F40);
    rc(7'h5C, 16'h0B40);
    core_status <= 9'h0E2;
    checker_sync_lost <= 1'b0;
    repeat (5) @(posedge aclk);
    core_status <= 9'h002;
    repeat (5) @(posedge aclk);
    rc(7'h5C, 16'h7080);
    rc(7'h5C, 16'h0080);
  endtask : t_status

  task automatic t_lamps;
    logic [10:0] ev;
    int          ones;
    wr(7'h60, 16'h0123);
    rc(7'h60, 16'h0123);
    for (int c = 0; c < 15; c++) begin
      wr(7'h60, {4{c[3:0]}});
      for (int i = 0; i < 13; i++) begin
        ev = (i == 12) ? 11'h404 : 11'(1) << i;
        lamp_events <= ev;
        repeat (10) @(posedge aclk);
        chk("lamp_out", {28'h0, {4{lamp_exp(c[3:0], ev)}}}, {28'h0, lamp_out});
      end
    end
    // copper link with activity: lamp blinks, lit for half of any 8 cycles
    wr(7'h60, 16'hBBBB);
    lamp_events <= 11'h604;
    repeat (10) @(posedge aclk);
    ones = 0;
    repeat (8) begin
      @(negedge aclk);
      ones += lamp_out[0];
    end
    chk("blink lit cycles", 32'h4, ones);
  endtask : t_lamps

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    t_reset_vals();
    t_bus_errors();
    t_self_test();
    t_err_count();
    t_freeze();
    t_status();
    t_lamps();
    conclude();
  end
endmodule : tb
